// ==== logic/afsk_cfg.svh ====
// constants for the afsk keyer tone counters
`ifndef AFSK_CFG_SVH
`define AFSK_CFG_SVH
`define AFSK_ADDR_SPACE 2'h1
`define AFSK_ADDR_MARK 2'h2
`define AFSK_ADDR_SETUP 2'h3
`define AFSK_SETUP_SPACE 8'h77
`define AFSK_SETUP_MARK 8'hb7
`define AFSK_SEL_LSB 6
`define AFSK_RL_LSB 4
`define AFSK_MODE_LSB 1
`define AFSK_BCD_BIT 0
`define AFSK_MODE_SQUARE 3'h3
`define AFSK_CORE_HZ 200000000
`define AFSK_TONE_HZ 1250000
`define AFSK_TONE_DIV (`AFSK_CORE_HZ / `AFSK_TONE_HZ)
`define AFSK_SPACE_85 16'h1151
`define AFSK_SPACE_170 16'h0576
`define AFSK_SPACE_850 16'h0258
`define AFSK_MARK_85 16'h1365
`define AFSK_MARK_170 16'h0683
`define AFSK_MARK_850 16'h0397
`endif

// ==== logic/afsk_pkg.sv ====
// types shared by both ends of the afsk keyer tone counters
package afsk_pkg;
    typedef enum logic [1:0] {
        afsk_shift_85 = 2'h0,
        afsk_shift_170 = 2'h1,
        afsk_shift_850 = 2'h2
    } afsk_shift_t;
    typedef enum logic [4:0] {
        afsk_st_idle = 5'h01,
        afsk_st_setup = 5'h02,
        afsk_st_low = 5'h04,
        afsk_st_high = 5'h08,
        afsk_st_done = 5'h10
    } afsk_prog_t;
endpackage

// ==== logic/afsk_prog_if.sv ====
// parallel programming port between host and tone counters
`timescale 1ns/1ps
interface afsk_prog_if;
    logic chip_sel_n;
    logic rd_n;
    logic wr_n;
    logic timer_addr_high;
    logic timer_addr_low;
    logic [7:0] data;
    modport device (
        input chip_sel_n, rd_n, wr_n, timer_addr_high, timer_addr_low, data
    );
    modport host (
        output chip_sel_n, rd_n, wr_n, timer_addr_high, timer_addr_low, data
    );
endinterface

// ==== logic/afsk_tone_dev.sv ====
// afsk keyer: input gating, counter enable flip-flop and tone counters
`timescale 1ns/1ps
`include "afsk_cfg.svh"
// Contract
// - hold low forces processed keyer to mark
// - hold high passes keying input inverted
// - sense control high inverts, low passes
// - enable flip-flop samples keyer on tone edges
// - flop true gates space, complement gates mark
// - three counters: converter, space, mark; only space and mark are built here
// - host writes setup word at address 3
// - host loads space at 1, mark at 2
// - host sets load width to two bytes
// - host selects square wave mode 0,1,1
// - format bit picks binary or BCD
// - host writes setup 0x77 and 0xb7
// - count loads low byte then high byte
// - chip select high blocks programming only
// - counter toggles only while gate high
// - high (N+1)/2 clocks, low N/2 floor
// - space counts 1151, 576, 258 BCD
// - mark counts 1365, 683, 397 BCD
// - tone counters tick at 1.25 MHz
// - centers 500, 1000, 2000 Hz
// - hold comes from a control register bit
// - combine outputs with nand then invert
// - divide by two only when keyed or testing
module afsk_tone_dev
    import afsk_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // programming port
    afsk_prog_if.device prog,
    // keying and control
    input wire logic keyer_data,
    input wire logic ctrl_wr,
    input wire logic [7:0] ctrl_data,
    input wire logic tx_keyed,
    // outputs
    output logic space_tone,
    output logic mark_tone,
    output logic tone_mix,
    output logic keyer_out,
    output logic space_gate,
    output logic [7:0] ctrl_reg
);
    logic [7:0] tick_cnt;
    logic tick;
    logic wr_d;
    logic wr_fall;
    logic hold_n;
    logic keyer_sense_invert;
    logic self_test;
    logic gated;
    logic sensed;
    logic mix_d;
    logic [1:0] lsb_pend;
    logic [1:0] armed;
    logic [1:0] gate;
    logic [1:0] out;
    logic [7:0] lsb_hold [2];
    logic [7:0] setup [2];
    logic [15:0] tone_period_count [2];
    logic [15:0] cur [2];

    // module serial control bus register: bit1 hold_n, bit0 sense, bit2 test
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ctrl_reg <= 8'h03;
        end else if (ctrl_wr) begin
            ctrl_reg <= ctrl_data;
        end
    end
    assign keyer_sense_invert = ctrl_reg[0];
    assign hold_n = ctrl_reg[1];
    assign self_test = ctrl_reg[2];

    // nand of data with hold: hold low yields constant mark
    assign gated = ~(keyer_data & hold_n);
    assign sensed = gated ^ keyer_sense_invert;

    // 1.25 MHz tick from the core clock
    always_ff @(posedge core_clk) begin
        if (!rst_n || tick) begin
            tick_cnt <= 8'h00;
        end else begin
            tick_cnt <= tick_cnt + 8'h01;
        end
    end
    assign tick = (tick_cnt == 8'(`AFSK_TONE_DIV - 1));

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wr_d <= 1'b1;
        end else begin
            wr_d <= prog.wr_n;
        end
    end
    // a write takes effect on the strobe's falling edge
    assign wr_fall = wr_d & ~prog.wr_n & ~prog.chip_sel_n
        & prog.rd_n;

    // counter 0 belongs to the converter and is not built here
    for (genvar i = 0; i < 2; i++) begin : g_ctr
        logic [1:0] addr;
        logic [1:0] sel_code;
        logic bcd;
        logic [15:0] dec;
        logic [15:0] next_cur;
        logic [15:0] half;
        logic [4:0] hv;
        logic hc;
        assign addr = {prog.timer_addr_high, prog.timer_addr_low};
        assign sel_code = 2'(i + 1);
        assign bcd = setup[i][`AFSK_BCD_BIT];

        // decrement, in BCD per decade when the format bit asks
        always_comb begin
            dec = cur[i] - 16'h0001;
            if (bcd) begin
                dec = cur[i];
                for (int d = 0; d < 4; d++) begin
                    if (dec[d*4 +: 4] != 4'h0) begin
                        dec[d*4 +: 4] = dec[d*4 +: 4] - 4'h1;
                        break;
                    end
                    dec[d*4 +: 4] = 4'h9;
                end
            end
        end

        always_ff @(posedge core_clk) begin
            if (!rst_n) begin
                setup[i] <= 8'h00;
                tone_period_count[i] <= 16'h0000;
                lsb_hold[i] <= 8'h00;
                lsb_pend[i] <= 1'b0;
                armed[i] <= 1'b0;
            end else if (wr_fall && addr == `AFSK_ADDR_SETUP
                    && prog.data[`AFSK_SEL_LSB +: 2] == sel_code) begin
                setup[i] <= prog.data;
                lsb_pend[i] <= 1'b0;
                armed[i] <= 1'b0;
            end else if (wr_fall && addr == sel_code) begin
                if (!lsb_pend[i]) begin
                    lsb_hold[i] <= prog.data;
                    lsb_pend[i] <= 1'b1;
                    armed[i] <= 1'b0;
                end else begin
                    tone_period_count[i] <= {prog.data, lsb_hold[i]};
                    lsb_pend[i] <= 1'b0;
                    armed[i] <= 1'b1;
                end
            end
        end

        // a binary shift would not halve a BCD count, so halve per decade
        always_comb begin
            half = tone_period_count[i] >> 1;
            hc = 1'b0;
            hv = 5'h00;
            if (bcd) begin
                for (int d = 3; d >= 0; d--) begin
                    hv = {1'b0, tone_period_count[i][d*4 +: 4]}
                        + (hc ? 5'h0a : 5'h00);
                    half[d*4 +: 4] = hv[4:1];
                    hc = hv[0];
                end
            end
        end

        // square wave: high for ceil(N/2) ticks, low for floor(N/2)
        always_comb begin
            next_cur = cur[i];
            if (cur[i] == 16'h0000 || cur[i] == 16'h0001) begin
                next_cur = tone_period_count[i];
            end else begin
                next_cur = dec;
            end
        end

        always_ff @(posedge core_clk) begin
            if (!rst_n) begin
                cur[i] <= 16'h0000;
                out[i] <= 1'b1;
            end else if (!armed[i] || !gate[i]) begin
                cur[i] <= 16'h0000;
                out[i] <= 1'b1;
            end else if (tick) begin
                cur[i] <= next_cur;
                if (cur[i] == 16'h0000 || cur[i] == 16'h0001) begin
                    out[i] <= 1'b1;
                end else if (out[i] && dec == half) begin
                    out[i] <= 1'b0;
                end
            end
        end
    end

    assign tone_mix = ~(~(out[0] & out[1]));
    assign space_tone = out[0];
    assign mark_tone = out[1];

    // enable flop clocked by the combined tone's rising edge
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            mix_d <= 1'b1;
            space_gate <= 1'b0;
        end else begin
            mix_d <= tone_mix;
            // idle counters rest high, so follow sense directly while both counters sit idle
            if ((tone_mix && !mix_d) || (gate == 2'b00)
                    || (!armed[0] && !armed[1])
                    || (out == 2'b11 && cur[0] == 16'h0000
                        && cur[1] == 16'h0000)) begin
                space_gate <= sensed;
            end
        end
    end
    assign gate = {~space_gate, space_gate};

    // output divide by two, held reset unless keyed or self test
    always_ff @(posedge core_clk) begin
        if (!rst_n || !(tx_keyed || self_test)) begin
            keyer_out <= 1'b0;
        end else if (tone_mix && !mix_d) begin
            keyer_out <= ~keyer_out;
        end
    end
endmodule

// ==== logic/afsk_tone_host.sv ====
// host end: programs setup words and counts into both tone counters
`timescale 1ns/1ps
`include "afsk_cfg.svh"
module afsk_tone_host
    import afsk_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // user side
    input wire logic start,
    input wire afsk_shift_t shift_sel,
    output logic busy,
    // programming port
    afsk_prog_if.host prog
);
    afsk_prog_t state;
    logic [1:0] step;
    logic strobe;
    logic which;
    logic [15:0] cnt;

    // counts per shift, loaded in BCD
    always_comb begin
        unique case (shift_sel)
            afsk_shift_170: cnt = which ? `AFSK_MARK_170 : `AFSK_SPACE_170;
            afsk_shift_850: cnt = which ? `AFSK_MARK_850 : `AFSK_SPACE_850;
            default: cnt = which ? `AFSK_MARK_85 : `AFSK_SPACE_85;
        endcase
    end

    // each access: set address and data, strobe low, strobe high
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state <= afsk_st_idle;
            step <= 2'h0;
            which <= 1'b0;
            strobe <= 1'b0;
        end else begin
            step <= step + 2'h1;
            // no strobe while the port is released
            strobe <= (step == 2'h1) && state != afsk_st_idle
                && state != afsk_st_done;
            unique case (state)
                afsk_st_idle: begin
                    step <= 2'h0;
                    which <= 1'b0;
                    if (start) begin
                        state <= afsk_st_setup;
                    end
                end
                afsk_st_setup: if (step == 2'h3) begin
                    state <= afsk_st_low;
                end
                afsk_st_low: if (step == 2'h3) begin
                    state <= afsk_st_high;
                end
                afsk_st_high: if (step == 2'h3) begin
                    which <= ~which;
                    state <= which ? afsk_st_done : afsk_st_setup;
                end
                afsk_st_done: state <= afsk_st_idle;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            prog.chip_sel_n <= 1'b1;
            prog.rd_n <= 1'b1;
            prog.wr_n <= 1'b1;
            prog.timer_addr_high <= 1'b0;
            prog.timer_addr_low <= 1'b0;
            prog.data <= 8'h00;
        end else begin
            prog.rd_n <= 1'b1;
            prog.chip_sel_n <= (state == afsk_st_idle
                || state == afsk_st_done);
            prog.wr_n <= ~strobe;
            unique case (state)
                afsk_st_setup: begin
                    {prog.timer_addr_high, prog.timer_addr_low}
                        <= `AFSK_ADDR_SETUP;
                    prog.data <= which ? `AFSK_SETUP_MARK : `AFSK_SETUP_SPACE;
                end
                afsk_st_low, afsk_st_high: begin
                    {prog.timer_addr_high, prog.timer_addr_low}
                        <= which ? `AFSK_ADDR_MARK : `AFSK_ADDR_SPACE;
                    prog.data <= (state == afsk_st_low) ? cnt[7:0] : cnt[15:8];
                end
                default: begin
                    prog.data <= 8'h00;
                end
            endcase
        end
    end
    assign busy = (state != afsk_st_idle);
endmodule

// ==== verification/afsk_keyer_asserts.sv ====
// assertions on the programming port and the combined tone
`timescale 1ns/1ps
`include "afsk_cfg.svh"
module afsk_keyer_asserts (
    // clock and reset
    input logic core_clk,
    input logic rst_n,
    // programming port
    input logic chip_sel_n,
    input logic rd_n,
    input logic wr_n,
    input logic timer_addr_high,
    input logic timer_addr_low,
    input logic [7:0] data,
    // tone outputs
    input logic space_tone,
    input logic mark_tone,
    input logic tone_mix,
    input logic space_gate
);
    logic wr_q;
    logic [1:0] sel_q;
    logic [1:0] n_load;
    wire [1:0] addr = {timer_addr_high, timer_addr_low};
    wire go = wr_q && !wr_n && !chip_sel_n && rd_n;
    wire setup = go && addr == `AFSK_ADDR_SETUP;
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    always_ff @(posedge core_clk)
        wr_q <= wr_n | ~rst_n;
    // a setup write restarts the byte pairing of its counter
    always_ff @(posedge core_clk)
        if (!rst_n || setup)
            n_load <= 2'h0;
        else if (go)
            n_load <= n_load + 2'h1;
    always_ff @(posedge core_clk)
        if (!rst_n)
            sel_q <= 2'h0;
        else if (setup)
            sel_q <= data[7:6];
    AST_NO_READ: assert property (rd_n)
        else $error("read strobe low");
    AST_WR_SEL: assert property ($fell(wr_n) |-> !chip_sel_n)
        else $error("write without select");
    AST_WR_PULSE: assert property ($fell(wr_n) |=> wr_n)
        else $error("strobe not raised between bytes");
    AST_HOLD: assert property ($fell(wr_n) |->
        $stable({addr, data}) ##1 $stable({addr, data}))
        else $error("address or data moved under strobe");
    AST_SETUP: assert property (setup |->
        data == `AFSK_SETUP_SPACE || data == `AFSK_SETUP_MARK)
        else $error("bad setup word");
    AST_FIELDS: assert property (setup |-> data[5:0] == 6'h37)
        else $error("bad load width or mode");
    AST_LOAD: assert property (go && !setup |->
        addr == sel_q && n_load < 2'h2)
        else $error("count byte out of order");
    AST_MIX: assert property (tone_mix == (space_tone && mark_tone))
        else $error("combined tone wrong");
    AST_REST: assert property (space_gate [*2] |-> mark_tone)
        else $error("idle mark counter low");
endmodule

// ==== verification/fsk_keyer_tone_counters_bench.sv ====
// self-checking bench: host and tone device face each other
`timescale 1ns/1ps
`include "afsk_cfg.svh"
module fsk_keyer_tone_counters_bench
    import afsk_pkg::*;
;
    localparam int DIV = `AFSK_TONE_DIV;
    localparam int MARK_N = 397;
    localparam int SPACE_N = 10;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic keyer_data = 1'b0;
    logic ctrl_wr = 1'b0;
    logic [7:0] ctrl_data = 8'h00;
    logic tx_keyed = 1'b0;
    logic start = 1'b0;
    afsk_shift_t shift_sel = afsk_shift_85;
    logic busy, space_tone, mark_tone, tone_mix, keyer_out, space_gate;
    logic tone2, lo, ko;
    logic [7:0] ctrl_reg;
    int n_mismatch = 0;
    int checked = 0;
    time t0, t_hit;
    wire [2:0] sigs = {busy, tone2, mark_tone};
    // each row: hold_n, sense, keyer input, expected space gate
    logic [3:0] rows [8] = '{4'h1, 4'h3, 4'h4, 4'h6, 4'h9, 4'ha, 4'hc, 4'hf};
    afsk_prog_if link();
    afsk_prog_if rogue();
    afsk_tone_host afsk_tone_host_i (
        .core_clk, .rst_n, .start, .shift_sel, .busy, .prog(link)
    );
    afsk_tone_dev afsk_tone_dev_i (
        .core_clk, .rst_n, .prog(link), .keyer_data, .ctrl_wr, .ctrl_data,
        .tx_keyed, .space_tone, .mark_tone, .tone_mix, .keyer_out,
        .space_gate, .ctrl_reg
    );
    // second device is driven by the bench, which may break byte pairing
    afsk_tone_dev afsk_tone_dev_i2 (
        .core_clk, .rst_n, .prog(rogue), .keyer_data, .ctrl_wr, .ctrl_data,
        .tx_keyed, .space_tone(tone2), .mark_tone(), .tone_mix(),
        .keyer_out(), .space_gate(), .ctrl_reg()
    );
    afsk_keyer_asserts afsk_keyer_asserts_i (
        .core_clk, .rst_n, .chip_sel_n(link.chip_sel_n), .rd_n(link.rd_n),
        .wr_n(link.wr_n), .timer_addr_high(link.timer_addr_high),
        .timer_addr_low(link.timer_addr_low), .data(link.data),
        .space_tone, .mark_tone, .tone_mix, .space_gate
    );
    always #2.5 core_clk = ~core_clk;
    task automatic chk(input string nm, input logic [31:0] e, g);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s: expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic bwr(input logic cs_n, input logic [1:0] a,
                       input logic [7:0] d);
        @(posedge core_clk);
        rogue.chip_sel_n <= cs_n;
        {rogue.timer_addr_high, rogue.timer_addr_low} <= a;
        rogue.data <= d;
        repeat (2) @(posedge core_clk);
        rogue.wr_n <= 1'b0;
        @(posedge core_clk);
        rogue.wr_n <= 1'b1;
        @(posedge core_clk);
        rogue.chip_sel_n <= 1'b1;
    endtask
    task automatic stop_test();
        $display("checked %0d, mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // times are taken at falling edges, where outputs have settled
    task automatic wait_lvl(input int w, input logic v, input int lim);
        int n = 0;
        @(negedge core_clk);
        while (sigs[w] !== v && n < lim) begin
            @(negedge core_clk);
            n++;
        end
        t_hit = $time;
        if (n >= lim) begin
            n_mismatch++;
            $display("unexpected output %0d: expected %b seen %b", w, v, ~v);
            stop_test();
        end
    endtask
    initial begin
        {rogue.chip_sel_n, rogue.rd_n, rogue.wr_n} = 3'h7;
        {rogue.timer_addr_high, rogue.timer_addr_low, rogue.data} = 10'h000;
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            @(posedge core_clk);
            ctrl_wr <= 1'b1;
            ctrl_data <= {6'h00, rows[i][3:2]};
            keyer_data <= rows[i][1];
            @(posedge core_clk);
            ctrl_wr <= 1'b0;
            repeat (4) @(negedge core_clk);
            chk("space_gate", rows[i][0], space_gate);
        end
        $display("keyer table done");
        bwr(1'b0, `AFSK_ADDR_SETUP, `AFSK_SETUP_SPACE);
        bwr(1'b0, `AFSK_ADDR_SPACE, 8'h10);
        lo = 1'b0;
        repeat (2000) begin
            @(negedge core_clk);
            lo = lo | ~tone2;
        end
        chk("half loaded tone", 1'b0, lo);
        bwr(1'b0, `AFSK_ADDR_SPACE, 8'h00);
        wait_lvl(1, 1'b0, 1500);
        t0 = t_hit;
        bwr(1'b1, `AFSK_ADDR_SETUP, 8'h76);
        wait_lvl(1, 1'b1, 1500);
        t0 = (t_hit - t0) / 5;
        chk("space low", SPACE_N / 2 * DIV, 32'(t0));
        bwr(1'b0, `AFSK_ADDR_SETUP, 8'h76);
        bwr(1'b0, `AFSK_ADDR_SPACE, 8'h10);
        bwr(1'b0, `AFSK_ADDR_SPACE, 8'h00);
        wait_lvl(1, 1'b0, 3000);
        t0 = t_hit;
        wait_lvl(1, 1'b1, 3000);
        t0 = (t_hit - t0) / 5;
        chk("binary low", 16 / 2 * DIV, 32'(t0));
        // a fresh setup and one byte must not rerun the old count
        bwr(1'b0, `AFSK_ADDR_SETUP, `AFSK_SETUP_SPACE);
        bwr(1'b0, `AFSK_ADDR_SPACE, 8'h10);
        lo = 1'b0;
        repeat (2000) begin
            @(negedge core_clk);
            lo = lo | ~tone2;
        end
        chk("relaunch tone", 1'b0, lo);
        $display("pairing test done");
        @(posedge core_clk);
        keyer_data <= 1'b0;
        tx_keyed <= 1'b1;
        for (int s = 0; s < 3; s++) begin
            repeat (4) @(posedge core_clk);
            shift_sel <= afsk_shift_t'(s);
            start <= 1'b1;
            @(posedge core_clk);
            start <= 1'b0;
            wait_lvl(2, 1'b1, 4);
            wait_lvl(2, 1'b0, 300);
        end
        $display("host programming done");
        wait_lvl(0, 1'b1, 40000);
        wait_lvl(0, 1'b0, 40000);
        t0 = t_hit;
        ko = ~keyer_out;
        @(posedge core_clk);
        keyer_data <= 1'b1;
        repeat (8) @(negedge core_clk);
        chk("space_gate", 1'b0, space_gate);
        wait_lvl(0, 1'b1, 40000);
        t0 = (t_hit - t0) / 5;
        chk("mark low", (MARK_N - 1) / 2 * DIV, 32'(t0));
        repeat (4) @(negedge core_clk);
        chk("space_gate", 1'b1, space_gate);
        chk("keyer_out", ko, keyer_out);
        @(posedge core_clk);
        tx_keyed <= 1'b0;
        repeat (2) @(negedge core_clk);
        chk("keyer_out", 1'b0, keyer_out);
        $display("tone test done");
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (16) @(negedge core_clk);
        chk("reset", 12'h03c,
            {ctrl_reg, space_tone, mark_tone, keyer_out, busy});
        $display("reset test done");
        stop_test();
    end
endmodule
